// [design/cbcd_pkg.sv]
package cbcd_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FLAGS  = 8'h08;
  localparam logic [7:0] OFS_PC     = 8'h0C;
  localparam logic [7:0] OFS_REGS   = 8'h40;
  localparam int         REG_COUNT  = 16;

  localparam logic [2:0] SIZE_WORD = 3'h2;

  // Operation codes in the command register
  localparam logic [2:0] OPC_COMPLEMENT = 3'h1;
  localparam logic [2:0] OPC_COMPARE    = 3'h2;
  localparam logic [2:0] OPC_CIJ_EQ     = 3'h3;
  localparam logic [2:0] OPC_CIJ_NE     = 3'h4;
  localparam logic [2:0] OPC_BCD        = 3'h5;

  // Command field positions
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_IND_BIT = 3;
  localparam int CMD_DST_LSB = 4;
  localparam int CMD_SRC_LSB = 8;
  localparam int CMD_OFS_LSB = 16;

  // Status bits
  localparam int STAT_BUSY  = 0;
  localparam int STAT_TAKEN = 1;

  // Flag bit positions
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;

  // Reset values
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [7:0]  REG_RST   = 8'h00;

  // Execution lengths in clock cycles
  localparam logic [4:0] CYC_COMPLEMENT = 5'h04;
  localparam logic [4:0] CYC_COMPARE    = 5'h06;
  localparam logic [4:0] CYC_BCD        = 5'h04;
  localparam logic [4:0] CYC_JUMP_TAKEN = 5'h12;
  localparam logic [4:0] CYC_JUMP_NOT   = 5'h10;

  // Decimal adjust corrections
  localparam logic [7:0] BCD_ADD_LOW  = 8'h06;
  localparam logic [7:0] BCD_ADD_HIGH = 8'h60;
  localparam logic [7:0] BCD_ADD_BOTH = 8'h66;
  localparam logic [7:0] BCD_SUB_LOW  = 8'hFA;
  localparam logic [7:0] BCD_SUB_HIGH = 8'hA0;
  localparam logic [7:0] BCD_SUB_BOTH = 8'h9A;
  localparam logic [7:0] BCD_NONE     = 8'h00;
  localparam logic [3:0] NIBBLE_MAX   = 4'h9;

  typedef enum logic {ST_IDLE, ST_EXEC} state_type;

  function automatic logic isRegSpace(input logic [7:0] a);
    return a[7:6] == OFS_REGS[7:6];
  endfunction : isRegSpace

  function automatic logic [3:0] regIndex(input logic [7:0] a);
    return a[5:2];
  endfunction : regIndex

endpackage : cbcd_pkg

// [design/alu_if.sv]
`timescale 1ns/1ps
interface alu_if;
  logic [2:0] op;
  logic [7:0] dstVal;
  logic [7:0] srcVal;
  logic [7:0] flagsIn;
  logic [7:0] result;
  logic [7:0] flagsOut;
  logic       diffZero;

  modport core (input op, dstVal, srcVal, flagsIn,
                output result, flagsOut, diffZero);
  modport user (output op, dstVal, srcVal, flagsIn,
                input result, flagsOut, diffZero);
endinterface : alu_if

// [design/alu_core.sv]
`timescale 1ns/1ps
module alu_core (
  alu_if.core alu
);

  logic [8:0] diff9;
  logic       lowFix;
  logic       highFix;
  logic [7:0] corr;

  always_comb begin
    diff9        = {1'b0, alu.dstVal} - {1'b0, alu.srcVal};
    alu.diffZero = diff9[7:0] == 8'h00;
    alu.result   = diff9[7:0];
    alu.flagsOut = alu.flagsIn;
    lowFix       = 1'b0;
    highFix      = 1'b0;
    corr         = cbcd_pkg::BCD_NONE;
    case (alu.op)
      cbcd_pkg::OPC_COMPLEMENT: begin
        alu.result = ~alu.dstVal;
        alu.flagsOut[cbcd_pkg::FLAG_Z] = ~alu.dstVal == 8'h00;
        alu.flagsOut[cbcd_pkg::FLAG_S] = ~alu.dstVal[7];
        alu.flagsOut[cbcd_pkg::FLAG_V] = 1'b0;
      end
      cbcd_pkg::OPC_COMPARE: begin
        alu.flagsOut[cbcd_pkg::FLAG_C] = diff9[8];
        alu.flagsOut[cbcd_pkg::FLAG_Z] = diff9[7:0] == 8'h00;
        alu.flagsOut[cbcd_pkg::FLAG_S] = diff9[7];
        alu.flagsOut[cbcd_pkg::FLAG_V] = (alu.dstVal[7] != alu.srcVal[7])
            && (diff9[7] != alu.dstVal[7]);
      end
      cbcd_pkg::OPC_BCD: begin
        if (!alu.flagsIn[cbcd_pkg::FLAG_D]) begin
          lowFix  = alu.flagsIn[cbcd_pkg::FLAG_H]
                    || (alu.dstVal[3:0] > cbcd_pkg::NIBBLE_MAX);
          highFix = alu.flagsIn[cbcd_pkg::FLAG_C]
                    || (alu.dstVal[7:4] > cbcd_pkg::NIBBLE_MAX)
                    || ((alu.dstVal[7:4] >= cbcd_pkg::NIBBLE_MAX)
                        && (alu.dstVal[3:0] > cbcd_pkg::NIBBLE_MAX));
          if (lowFix && highFix) begin
            corr = cbcd_pkg::BCD_ADD_BOTH;
          end else if (highFix) begin
            corr = cbcd_pkg::BCD_ADD_HIGH;
          end else if (lowFix) begin
            corr = cbcd_pkg::BCD_ADD_LOW;
          end
          alu.flagsOut[cbcd_pkg::FLAG_C] = highFix;
        end else begin
          lowFix  = alu.flagsIn[cbcd_pkg::FLAG_H];
          highFix = alu.flagsIn[cbcd_pkg::FLAG_C];
          if (lowFix && highFix) begin
            corr = cbcd_pkg::BCD_SUB_BOTH;
          end else if (highFix) begin
            corr = cbcd_pkg::BCD_SUB_HIGH;
          end else if (lowFix) begin
            corr = cbcd_pkg::BCD_SUB_LOW;
          end
        end
        alu.result = alu.dstVal + corr;
        alu.flagsOut[cbcd_pkg::FLAG_Z] = alu.result == 8'h00;
        alu.flagsOut[cbcd_pkg::FLAG_S] = alu.result[7];
      end
      default: begin
        alu.flagsOut = alu.flagsIn;
      end
    endcase
  end

endmodule : alu_core

// [design/complement_compare_bcd_adjust.sv]
// Contract
// - Complement inverts destination byte, writes back
// - Complement: Z on zero, S bit7, V cleared
// - Complement destination direct or indirect through register
// - Compare subtracts, flags only, operands untouched
// - Compare sets C borrow, Z, S, V
// - Jump-on-equal adds offset when difference zero
// - Jump-on-equal increments pointer always, flags untouched
// - Jump-on-non-equal adds offset when difference nonzero
// - Jump-on-non-equal increments pointer always, flags untouched
// - Compare-jumps last 18 taken, 16 not taken
// - Relative offset is a signed byte
// - Add adjust: 06, 60, 66, carry on high
// - Subtract adjust: FA, A0, 9A, carry kept
// - Adjust defined only after valid BCD arithmetic
// - Adjust flags: C carry, Z, S bit7
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module complement_compare_bcd_adjust (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);

  logic [7:0]           regs_r [cbcd_pkg::REG_COUNT];
  logic [7:0]           flags_r;
  logic [15:0]          pc_r;
  cbcd_pkg::state_type  state_r;
  logic [4:0]           cycLeft_r;
  logic [2:0]           opc_r;
  logic [3:0]           dstAddr_r;
  logic [3:0]           ptrAddr_r;
  logic [7:0]           dstVal_r;
  logic [7:0]           srcVal_r;
  logic [7:0]           offset_r;
  logic                 taken_r;

  logic                 wrPend_r;
  logic [7:0]           wrAddr_r;
  logic                 rdPend_r;
  logic [7:0]           rdAddr_r;
  logic                 hreadyout_r;
  logic [31:0]          hrdata_r;
  logic                 hresp_r;

  logic                 addrPhase;
  logic                 busWr;
  logic                 idle;
  logic                 cmdWrite;
  logic                 commit;
  logic [2:0]           cmdOp;
  logic                 cmdInd;
  logic [3:0]           cmdDst;
  logic [3:0]           cmdSrc;
  logic [7:0]           cmdOfs;
  logic                 cmdJump;
  logic                 cmdValid;
  logic [3:0]           dstEff;
  logic [3:0]           srcEff;
  logic                 operandsEqual;
  logic                 takenNow;
  logic [4:0]           cycLoad;
  logic [15:0]          jumpTarget;
  logic                 opJump;

  alu_if alu ();

  alu_core u_alu (
    .alu (alu.core)
  );

  assign alu.op      = opc_r;
  assign alu.dstVal  = dstVal_r;
  assign alu.srcVal  = srcVal_r;
  assign alu.flagsIn = flags_r;

  assign hreadyout = hreadyout_r;
  assign hrdata    = hrdata_r;
  assign hresp     = hresp_r;

  // Bus decode
  assign addrPhase = hsel && htrans[1] && hready
                     && (hsize == cbcd_pkg::SIZE_WORD);
  assign busWr     = wrPend_r && hready;
  assign idle      = state_r == cbcd_pkg::ST_IDLE;
  assign cmdWrite  = busWr && idle && (wrAddr_r == cbcd_pkg::OFS_CMD);

  // Command fields
  assign cmdOp   = hwdata[cbcd_pkg::CMD_OP_LSB +: 3];
  assign cmdInd  = hwdata[cbcd_pkg::CMD_IND_BIT];
  assign cmdDst  = hwdata[cbcd_pkg::CMD_DST_LSB +: 4];
  assign cmdSrc  = hwdata[cbcd_pkg::CMD_SRC_LSB +: 4];
  assign cmdOfs  = hwdata[cbcd_pkg::CMD_OFS_LSB +: 8];
  assign cmdJump = (cmdOp == cbcd_pkg::OPC_CIJ_EQ)
                   || (cmdOp == cbcd_pkg::OPC_CIJ_NE);
  assign cmdValid = (cmdOp >= cbcd_pkg::OPC_COMPLEMENT)
                    && (cmdOp <= cbcd_pkg::OPC_BCD);

  // Indirect mode fetches the target index from a register
  assign dstEff = (cmdInd && !cmdJump) ? regs_r[cmdDst][3:0]
                                       : cmdDst;
  // Compare-jumps always read the source through the pointer
  assign srcEff = (cmdInd || cmdJump) ? regs_r[cmdSrc][3:0] : cmdSrc;

  assign operandsEqual = regs_r[dstEff] == regs_r[srcEff];
  assign takenNow      = (cmdOp == cbcd_pkg::OPC_CIJ_EQ)
                         ? operandsEqual
                         : !operandsEqual;

  always_comb begin
    case (cmdOp)
      cbcd_pkg::OPC_COMPLEMENT: begin
        cycLoad = cbcd_pkg::CYC_COMPLEMENT;
      end
      cbcd_pkg::OPC_COMPARE: begin
        cycLoad = cbcd_pkg::CYC_COMPARE;
      end
      cbcd_pkg::OPC_CIJ_EQ, cbcd_pkg::OPC_CIJ_NE: begin
        cycLoad = takenNow ? cbcd_pkg::CYC_JUMP_TAKEN
                           : cbcd_pkg::CYC_JUMP_NOT;
      end
      cbcd_pkg::OPC_BCD: begin
        cycLoad = cbcd_pkg::CYC_BCD;
      end
      default: begin
        cycLoad = 5'h01;
      end
    endcase
  end

  assign commit = (state_r == cbcd_pkg::ST_EXEC) && (cycLeft_r == 5'h00);
  assign opJump = (opc_r == cbcd_pkg::OPC_CIJ_EQ)
                  || (opc_r == cbcd_pkg::OPC_CIJ_NE);
  assign jumpTarget = pc_r + {{8{offset_r[7]}}, offset_r};

  // Sequencing of one operation
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= cbcd_pkg::ST_IDLE;
      cycLeft_r <= 5'h00;
    end else begin
      case (state_r)
        cbcd_pkg::ST_IDLE: begin
          if (cmdWrite && cmdValid) begin
            state_r   <= cbcd_pkg::ST_EXEC;
            cycLeft_r <= cycLoad - 5'h01;
          end
        end
        cbcd_pkg::ST_EXEC: begin
          if (commit) begin
            state_r <= cbcd_pkg::ST_IDLE;
          end else begin
            cycLeft_r <= cycLeft_r - 5'h01;
          end
        end
        default: begin
          state_r <= cbcd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Operand capture at command acceptance
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      opc_r     <= 3'h0;
      dstAddr_r <= 4'h0;
      ptrAddr_r <= 4'h0;
      dstVal_r  <= 8'h00;
      srcVal_r  <= 8'h00;
      offset_r  <= 8'h00;
      taken_r   <= 1'b0;
    end else if (cmdWrite && cmdValid) begin
      opc_r     <= cmdOp;
      dstAddr_r <= dstEff;
      ptrAddr_r <= cmdSrc;
      dstVal_r  <= regs_r[dstEff];
      srcVal_r  <= regs_r[srcEff];
      offset_r  <= cmdOfs;
      taken_r   <= cmdJump && takenNow;
    end
  end

  // Register file: bus writes when idle, results at commit
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < cbcd_pkg::REG_COUNT; i++) begin
        regs_r[i] <= cbcd_pkg::REG_RST;
      end
    end else if (commit) begin
      case (opc_r)
        cbcd_pkg::OPC_COMPLEMENT, cbcd_pkg::OPC_BCD: begin
          regs_r[dstAddr_r] <= alu.result;
        end
        cbcd_pkg::OPC_CIJ_EQ, cbcd_pkg::OPC_CIJ_NE: begin
          regs_r[ptrAddr_r] <= regs_r[ptrAddr_r] + 8'h01;
        end
        default: begin
          // Compare leaves every register alone
        end
      endcase
    end else if (busWr && idle && cbcd_pkg::isRegSpace(wrAddr_r)) begin
      regs_r[cbcd_pkg::regIndex(wrAddr_r)] <= hwdata[7:0];
    end
  end

  // Flags: updated at commit except on compare-jumps, on the same edge that busy falls
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags_r <= cbcd_pkg::FLAGS_RST;
    end else if (commit) begin
      if (!opJump) begin
        flags_r <= alu.flagsOut;
      end
    end else if (busWr && idle && (wrAddr_r == cbcd_pkg::OFS_FLAGS)) begin
      flags_r <= hwdata[7:0];
    end
  end

  // Program counter holds the reference address of the next operation
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pc_r <= cbcd_pkg::PC_RST;
    end else if (commit) begin
      if (opJump
          && (alu.diffZero == (opc_r == cbcd_pkg::OPC_CIJ_EQ))) begin
        pc_r <= jumpTarget;
      end
    end else if (busWr && idle && (wrAddr_r == cbcd_pkg::OFS_PC)) begin
      pc_r <= hwdata[15:0];
    end
  end

  // Bus pipeline: writes zero-wait, reads one wait state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_r    <= 1'b0;
      wrAddr_r    <= 8'h00;
      rdPend_r    <= 1'b0;
      rdAddr_r    <= 8'h00;
      hreadyout_r <= 1'b1;
    end else begin
      if (hready) begin
        wrPend_r <= addrPhase && hwrite;
        rdPend_r <= addrPhase && !hwrite;
        if (addrPhase) begin
          wrAddr_r <= haddr[7:0];
          rdAddr_r <= haddr[7:0];
        end
        hreadyout_r <= !(addrPhase && !hwrite);
      end else if (rdPend_r) begin
        rdPend_r    <= 1'b0;
        hreadyout_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rdPend_r && !hready) begin
      hrdata_r <= 32'h0000_0000;
      if (cbcd_pkg::isRegSpace(rdAddr_r)) begin
        hrdata_r[7:0] <= regs_r[cbcd_pkg::regIndex(rdAddr_r)];
      end else begin
        case (rdAddr_r)
          cbcd_pkg::OFS_STATUS: begin
            hrdata_r[cbcd_pkg::STAT_BUSY]  <= !idle;
            hrdata_r[cbcd_pkg::STAT_TAKEN] <= taken_r;
          end
          cbcd_pkg::OFS_FLAGS: begin
            hrdata_r[7:0] <= flags_r;
          end
          cbcd_pkg::OFS_PC: begin
            hrdata_r[15:0] <= pc_r;
          end
          default: begin
            hrdata_r <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hresp_r <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
    end
  end

endmodule : complement_compare_bcd_adjust

// [dv/cbcd_properties.sv]
`timescale 1ns/1ps
module cbcd_properties (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp
);
  logic       addrOk;
  logic       rdOk;
  logic       cmdPend_r;
  logic [2:0] sinceCmd_r;
  assign addrOk = hsel && htrans[1] && hready
                  && (hsize == cbcd_pkg::SIZE_WORD);
  assign rdOk = addrOk && !hwrite;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmdPend_r <= 1'b0;
    end else if (hready) begin
      cmdPend_r <= addrOk && hwrite && haddr[7:0] == cbcd_pkg::OFS_CMD;
    end
  end
  // Cycles since a valid command was taken
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sinceCmd_r <= 3'h0;
    end else if (cmdPend_r && hwdata[2:0] >= cbcd_pkg::OPC_COMPLEMENT
                 && hwdata[2:0] <= cbcd_pkg::OPC_BCD) begin
      sinceCmd_r <= 3'h1;
    end else if (sinceCmd_r != 3'h0) begin
      sinceCmd_r <= sinceCmd_r + 3'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("error response seen");
  property p_read_wait;
    rdOk |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state wrong");
  property p_write_nowait;
    addrOk && hwrite |=> hreadyout;
  endproperty
  a_write_nowait: assert property (p_write_nowait)
    else $error("write was stalled");
  property p_wait_cause;
    $fell(hreadyout) |-> $past(rdOk);
  endproperty
  a_wait_cause: assert property (p_wait_cause)
    else $error("wait state without read");
  property p_cmd_rd0;
    rdOk && haddr[7:0] == cbcd_pkg::OFS_CMD |-> ##2 hrdata == 32'h0;
  endproperty
  a_cmd_rd0: assert property (p_cmd_rd0)
    else $error("command word not read as zero");
  property p_unmapped;
    rdOk && haddr[7:0] inside {[8'h10:8'h3C]} |-> ##2 hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_busy_seen;
    rdOk && haddr[7:0] == cbcd_pkg::OFS_STATUS
      && sinceCmd_r inside {[3'h1:3'h3]} |-> ##2 hrdata[0];
  endproperty
  a_busy_seen: assert property (p_busy_seen)
    else $error("busy low too early");
  property p_flags_high;
    rdOk && haddr[7:0] == cbcd_pkg::OFS_FLAGS
      |-> ##2 hrdata[31:8] == 24'h0;
  endproperty
  a_flags_high: assert property (p_flags_high)
    else $error("flags upper bits set");
  c_read: cover property (rdOk ##2 hreadyout);
  c_write: cover property (addrOk && hwrite);
  c_busy: cover property (sinceCmd_r == 3'h3 && rdOk);
endmodule : cbcd_properties

bind complement_compare_bcd_adjust cbcd_properties cbcd_properties_i (
  .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp)
);

// [dv/cpu_sequencer_model.sv]
`timescale 1ns/1ps
module cpu_sequencer_model (
  input wire logic   clock,
  input wire logic   hready,
  input wire logic [31:0] hrdata,
  output logic       hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic       hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic       hung
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = cbcd_pkg::SIZE_WORD;
    hwdata = 32'h0;
    hung = 1'b0;
  end
  task automatic waitReady();
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (k >= 64) begin
      hung <= 1'b1;
    end
  endtask : waitReady
  task automatic addrPhase(input logic [7:0] a, input logic w);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    waitReady();
    hsel <= 1'b0;
    haddr <= ~{24'h0, a};
    htrans <= 2'b00;
  endtask : addrPhase
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addrPhase(a, 1'b1);
    hwdata <= d;
    waitReady();
    hwdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addrPhase(a, 1'b0);
    waitReady();
    d = hrdata;
  endtask : rd
endmodule : cpu_sequencer_model

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, hung;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  int          bad_count = 0;
  int          n_checks = 0;
  logic [7:0]  cd [3] = '{8'h02, 8'h80, 8'h33};
  logic [7:0]  cs [3] = '{8'h03, 8'h01, 8'h33};
  logic [7:0]  cf [3] = '{8'hAC, 8'h1C, 8'h4C};
  logic [7:0]  jv [6] = '{8'h02, 8'h03, 8'h02, 8'h05, 8'h02, 8'h03};
  logic [2:0]  jop [4] = '{3'h3, 3'h3, 3'h4, 3'h4};
  logic [7:0]  jofs [4] = '{8'h80, 8'h10, 8'h10, 8'h7F};
  logic [15:0] jpc [4] = '{16'h0080, 16'h0080, 16'h0080, 16'h00FF};
  logic        jtk [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0]  bv [9] = '{8'h3C, 8'hA0, 8'h9A, 8'h12, 8'h25,
                          8'h31, 8'h0F, 8'hF5, 8'h66};
  logic [7:0]  bf [9] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h80,
                          8'h08, 8'h0C, 8'h88, 8'h8C};
  logic [7:0]  br [9] = '{8'h42, 8'h00, 8'h00, 8'h18, 8'h85,
                          8'h31, 8'h09, 8'h95, 8'h00};
  logic [7:0]  bo [9] = '{8'h00, 8'hC0, 8'hC0, 8'h04, 8'hA0,
                          8'h08, 8'h0C, 8'hA8, 8'hCC};
  always #2 clock = ~clock;
  complement_compare_bcd_adjust complement_compare_bcd_adjust_i (
    .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp));
  cpu_sequencer_model cpu_sequencer_model_i (
    .clock(clock), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hung(hung));
  task automatic final_report();
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  always @(posedge hung) begin
    bad_count++;
    final_report();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] ra(input logic [3:0] i);
    return cbcd_pkg::OFS_REGS + {2'b00, i, 2'b00};
  endfunction : ra
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    cpu_sequencer_model_i.rd(a, d);
    check(d, exp);
  endtask : rchk
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    cpu_sequencer_model_i.wr(a, {24'h0, v});
  endtask : wreg
  // Early reads status at the end edge, late one cycle after it
  task automatic exec(input logic [2:0] op, input logic ind,
                      input logic [3:0] dst, input logic [3:0] src,
                      input logic [7:0] ofs, input int n, input logic late);
    cpu_sequencer_model_i.wr(cbcd_pkg::OFS_CMD,
                             {8'h00, ofs, 4'h0, src, dst, ind, op});
    repeat (n - 2 + int'(late)) @(posedge clock);
    cpu_sequencer_model_i.rd(cbcd_pkg::OFS_STATUS, d);
    check({31'h0, d[0]}, {31'h0, ~late});
  endtask : exec
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rchk(cbcd_pkg::OFS_FLAGS, 32'h0);
    rchk(cbcd_pkg::OFS_PC, 32'h0);
    rchk(cbcd_pkg::OFS_CMD, 32'h0);
    wreg(8'h20, 8'h5A);
    rchk(8'h20, 32'h0);
    wreg(ra(1), 8'h07);
    wreg(ra(7), 8'hFF);
    wreg(cbcd_pkg::OFS_FLAGS, 8'h9C);
    exec(cbcd_pkg::OPC_COMPLEMENT, 1'b0, 4'h1, 4'h0, 8'h00, 4, 1'b1);
    rchk(ra(1), 32'hF8);
    rchk(cbcd_pkg::OFS_FLAGS, 32'hAC);
    wreg(ra(1), 8'h07);
    exec(cbcd_pkg::OPC_COMPLEMENT, 1'b1, 4'h1, 4'h0, 8'h00, 4, 1'b0);
    rchk(ra(7), 32'h00);
    rchk(ra(1), 32'h07);
    rchk(cbcd_pkg::OFS_FLAGS, 32'hCC);
    wreg(cbcd_pkg::OFS_FLAGS, 8'h5C);
    for (int i = 0; i < 3; i++) begin
      wreg(ra(2), cd[i]);
      wreg(ra(3), cs[i]);
      exec(cbcd_pkg::OPC_COMPARE, 1'b0, 4'h2, 4'h3, 8'h00, 6, i[0]);
      rchk(cbcd_pkg::OFS_FLAGS, {24'h0, cf[i]});
      rchk(ra(2), {24'h0, cd[i]});
      rchk(ra(3), {24'h0, cs[i]});
    end
    for (int i = 0; i < 6; i++) begin
      wreg(ra(4'(i + 1)), jv[i]);
    end
    cpu_sequencer_model_i.wr(cbcd_pkg::OFS_PC, 32'h0100);
    wreg(cbcd_pkg::OFS_FLAGS, 8'h5C);
    for (int i = 0; i < 4; i++) begin
      exec(jop[i], 1'b0, 4'h1, 4'h2, jofs[i], jtk[i] ? 18 : 16, i[0]);
      rchk(cbcd_pkg::OFS_PC, {16'h0, jpc[i]});
      rchk(ra(2), 32'(i + 4));
      rchk(cbcd_pkg::OFS_STATUS, {30'h0, jtk[i], 1'b0});
      rchk(cbcd_pkg::OFS_FLAGS, 32'h5C);
    end
    for (int i = 0; i < 9; i++) begin
      wreg(ra(0), bv[i]);
      wreg(cbcd_pkg::OFS_FLAGS, bf[i]);
      exec(cbcd_pkg::OPC_BCD, 1'b0, 4'h0, 4'h0, 8'h00, 4, 1'b1);
      rchk(ra(0), {24'h0, br[i]});
      rchk(cbcd_pkg::OFS_FLAGS, {24'h0, bo[i]});
    end
    // Write while busy must be dropped, busy seen early
    cpu_sequencer_model_i.wr(cbcd_pkg::OFS_CMD, 32'h0000_0011);
    wreg(ra(5), 8'h55);
    rchk(cbcd_pkg::OFS_STATUS, 32'h1);
    rchk(ra(5), 32'h02);
    rchk(ra(1), 32'hFD);
    rchk(cbcd_pkg::OFS_FLAGS, 32'hAC);
    final_report();
  end
endmodule : tb_top
